// ===== verilog/spmc_top.sv
// Port lines, interrupt requests and configuration register behind APB.
// Assumes one clock, synchronous resets and synchronous pin inputs.
module spmc_top #(
  parameter logic [7:0] PART_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] MASK_REV = 8'h01 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_reset_n,
  input wire logic i_freeze,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [2:0] i_pprot,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic [15:0] i_alt_ab_out,
  output logic [15:0] o_port_ab_lines,
  input wire logic [31:0] i_alt_ijkl_out,
  input wire logic [31:0] i_alt_ijkl_oe,
  input wire logic [31:0] i_port_ijkl_in,
  output logic [31:0] o_port_ijkl_out,
  output logic [31:0] o_port_ijkl_oe,
  input wire logic [7:0] i_port_m_in,
  output logic [7:0] o_port_m_out,
  output logic [7:0] o_port_m_oe,
  input wire logic [7:0] i_port_q_in,
  output logic [7:0] o_port_q_out,
  output logic [7:0] o_port_q_oe,
  output logic [7:0] o_irq_request,
  output logic o_irq,
  output logic o_reset_indication,
  output logic o_timer_stop,
  output spmc_pkg::spmc_cfg_t o_config
);
  import spmc_pkg::*;

  // Either reset source holds the whole block in reset
  logic rstn_int;
  assign rstn_int = i_rstn && i_ext_reset_n;

  // Register state
  spmc_cfg_t cfg_q;
  spmc_cfg_t cfg_d;
  logic [15:0] ab_data_q;
  logic [15:0] ab_fsel_q;
  logic [31:0] ijkl_data_q;
  logic [31:0] ijkl_dir_q;
  logic [31:0] ijkl_fsel_q;
  logic [7:0] m_data_q;
  logic [7:0] m_dir_q;
  logic [7:0] q_data_q;
  logic [7:0] q_dir_q;
  logic [7:0] q_isel_q;
  logic [STS_W-1:0] sts_q;
  logic [STS_W-1:0] sts_d;
  logic [STS_W-1:0] ien_q;
  logic irq_q;
  logic [7:0] irq_req_q;
  logic rst_ind_q;
  logic tstop_q;

  // Sampled pins
  logic [15:0] ab_in_unused;
  logic [31:0] ijkl_in;
  logic [7:0] m_in;
  logic [7:0] q_in;

  // Address decode
  logic hit_cfg;
  logic hit_ab_data;
  logic hit_ab_fsel;
  logic hit_ijkl_data;
  logic hit_ijkl_dir;
  logic hit_ijkl_fsel;
  logic hit_m_data;
  logic hit_m_dir;
  logic hit_q_data;
  logic hit_q_dir;
  logic hit_q_isel;
  logic hit_sts;
  logic hit_clr;
  logic hit_ien;
  logic hit_port;
  logic hit_slow;
  logic hit_any;
  assign hit_cfg = i_paddr == A_CFG;
  assign hit_ab_data = i_paddr == A_AB_DATA;
  assign hit_ab_fsel = i_paddr == A_AB_FSEL;
  assign hit_ijkl_data = i_paddr == A_IJKL_DATA;
  assign hit_ijkl_dir = i_paddr == A_IJKL_DIR;
  assign hit_ijkl_fsel = i_paddr == A_IJKL_FSEL;
  assign hit_m_data = i_paddr == A_M_DATA;
  assign hit_m_dir = i_paddr == A_M_DIR;
  assign hit_q_data = i_paddr == A_Q_DATA;
  assign hit_q_dir = i_paddr == A_Q_DIR;
  assign hit_q_isel = i_paddr == A_Q_IRQSEL;
  assign hit_sts = i_paddr == A_INT_STATUS;
  assign hit_clr = i_paddr == A_INT_CLEAR;
  assign hit_ien = i_paddr == A_INT_ENABLE;
  assign hit_slow = hit_ab_data || hit_ab_fsel || hit_ijkl_data
    || hit_ijkl_dir || hit_ijkl_fsel;
  assign hit_port = hit_slow || hit_m_data || hit_m_dir || hit_q_data
    || hit_q_dir || hit_q_isel;
  assign hit_any = hit_cfg || hit_port || hit_sts || hit_clr || hit_ien;

  // Access checks
  logic priv_mode;
  logic cfg_priv_err;
  logic cfg_lock_err;
  logic port_priv_err;
  logic acc_err;
  logic [1:0] need;
  assign priv_mode = i_pprot[0];
  assign cfg_priv_err = hit_cfg && !priv_mode;
  assign cfg_lock_err = hit_cfg && priv_mode && i_pwrite
    && cfg_q.register_lock_bit && !i_freeze;
  assign port_priv_err = hit_port
    && !priv_ok(cfg_q.privilege_field, priv_mode, i_pwrite);
  assign acc_err = !hit_any || cfg_priv_err || cfg_lock_err || port_priv_err;
  assign need = hit_slow ? LAT_SLOW : LAT_FAST;

  // Completing edge of a transfer
  logic fire;
  logic wr_ok;
  logic lock_event;
  assign fire = i_psel && i_penable && o_pready;
  assign wr_ok = fire && i_pwrite && !acc_err;
  assign lock_event = fire && cfg_lock_err;

  // Read data
  logic [31:0] cfg_rd;
  logic [31:0] rd_val;
  always_comb begin
    cfg_rd = 32'h0;
    cfg_rd[B_FRZ] = cfg_q.timer_freeze_enable;
    cfg_rd[B_CHKSTOP] = cfg_q.checkstop_reset_enable;
    cfg_rd[B_BURST] = cfg_q.burst_style_select;
    cfg_rd[B_PRIV_HI:B_PRIV_LO] = cfg_q.privilege_field;
    cfg_rd[B_DBG_LOCK] = cfg_q.debug_lock_bit;
    cfg_rd[B_REG_LOCK] = cfg_q.register_lock_bit;
    cfg_rd[B_SHOW_HI:B_SHOW_LO] = cfg_q.internal_bus_show_cycles;
    cfg_rd[B_PART_HI:B_PART_LO] = PART_CODE;
    cfg_rd[B_MASK_HI:B_MASK_LO] = MASK_REV;
  end
  assign rd_val =
    hit_cfg ? cfg_rd :
    hit_ab_data ? {16'h0, ab_data_q} :
    hit_ab_fsel ? {16'h0, ab_fsel_q} :
    hit_ijkl_data ? mix(ijkl_data_q, ijkl_in, ijkl_dir_q) :
    hit_ijkl_dir ? ijkl_dir_q :
    hit_ijkl_fsel ? ijkl_fsel_q :
    hit_m_data ? mix({24'h0, m_data_q}, {24'h0, m_in}, {24'h0, m_dir_q}) :
    hit_m_dir ? {24'h0, m_dir_q} :
    hit_q_data ? mix({24'h0, q_data_q}, {24'h0, q_in},
                     {24'h0, q_dir_q & ~q_isel_q}) :
    hit_q_dir ? {24'h0, q_dir_q} :
    hit_q_isel ? {24'h0, q_isel_q} :
    hit_sts ? {23'h0, sts_q} :
    hit_ien ? {23'h0, ien_q} :
    32'h0;

  spmc_wait u_wait (
    .i_clk(i_clk),
    .i_rstn(rstn_int),
    .i_psel(i_psel),
    .i_need(need),
    .i_err(acc_err),
    .i_rdata(rd_val),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_prdata(o_prdata)
  );

  // Configuration write
  logic [1:0] show_wr;
  logic show_ok;
  logic cfg_wr;
  assign cfg_wr = wr_ok && hit_cfg;
  assign show_wr = i_pwdata[B_SHOW_HI:B_SHOW_LO];
  assign show_ok = !cfg_q.debug_lock_bit && show_wr != SHOW_RESERVED;
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d.timer_freeze_enable = i_pwdata[B_FRZ];
      cfg_d.checkstop_reset_enable = i_pwdata[B_CHKSTOP];
      cfg_d.burst_style_select = i_pwdata[B_BURST];
      cfg_d.privilege_field = i_pwdata[B_PRIV_HI:B_PRIV_LO];
      if (show_ok) begin
        cfg_d.internal_bus_show_cycles = show_wr;
      end
      if (i_freeze) begin
        cfg_d.debug_lock_bit = i_pwdata[B_DBG_LOCK];
        cfg_d.register_lock_bit = i_pwdata[B_REG_LOCK];
      end else begin
        cfg_d.register_lock_bit = cfg_q.register_lock_bit
          | i_pwdata[B_REG_LOCK];
      end
    end
  end

  // Interrupt status: set wins over clear
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;
  logic [7:0] irq_lvl;
  assign irq_lvl = q_isel_q & q_in;
  assign sts_set = {lock_event, irq_lvl};
  assign sts_clr = (wr_ok && hit_clr) ? i_pwdata[STS_W-1:0] : '0;
  assign sts_d = (sts_q & ~sts_clr) | sts_set;

  always_ff @(posedge i_clk) begin
    if (!rstn_int) begin
      cfg_q <= CFG_RESET;
      sts_q <= '0;
      irq_q <= 1'b0;
      irq_req_q <= 8'h0;
      rst_ind_q <= 1'b1;
      tstop_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      sts_q <= sts_d;
      irq_q <= |(sts_q & ien_q);
      irq_req_q <= irq_lvl;
      rst_ind_q <= 1'b0;
      tstop_q <= cfg_q.timer_freeze_enable && i_freeze;
    end
  end

  // Port and enable registers
  always_ff @(posedge i_clk) begin
    if (!rstn_int) begin
      ab_data_q <= 16'h0;
      ab_fsel_q <= 16'h0;
      ijkl_data_q <= 32'h0;
      ijkl_dir_q <= 32'h0;
      ijkl_fsel_q <= 32'h0;
      m_data_q <= 8'h0;
      m_dir_q <= 8'h0;
      q_data_q <= 8'h0;
      q_dir_q <= 8'h0;
      q_isel_q <= 8'h0;
      ien_q <= '0;
    end else if (wr_ok) begin
      if (hit_ab_data) ab_data_q <= i_pwdata[15:0];
      if (hit_ab_fsel) ab_fsel_q <= i_pwdata[15:0];
      if (hit_ijkl_data) ijkl_data_q <= i_pwdata;
      if (hit_ijkl_dir) ijkl_dir_q <= i_pwdata;
      if (hit_ijkl_fsel) ijkl_fsel_q <= i_pwdata;
      if (hit_m_data) m_data_q <= i_pwdata[7:0];
      if (hit_m_dir) m_dir_q <= i_pwdata[7:0];
      if (hit_q_data) q_data_q <= i_pwdata[7:0];
      if (hit_q_dir) q_dir_q <= i_pwdata[7:0];
      if (hit_q_isel) q_isel_q <= i_pwdata[7:0];
      if (hit_ien) ien_q <= i_pwdata[STS_W-1:0];
    end
  end

  // Pin stages
  spmc_port #(.W(16)) u_ab (
    .i_clk(i_clk),
    .i_rstn(rstn_int),
    .i_data(ab_data_q),
    .i_dir(16'hFFFF),
    .i_fsel(ab_fsel_q),
    .i_alt_out(i_alt_ab_out),
    .i_alt_oe(16'hFFFF),
    .i_pin(16'h0),
    .o_out(o_port_ab_lines),
    .o_oe(),
    .o_in(ab_in_unused)
  );

  spmc_port #(.W(32)) u_ijkl (
    .i_clk(i_clk),
    .i_rstn(rstn_int),
    .i_data(ijkl_data_q),
    .i_dir(ijkl_dir_q),
    .i_fsel(ijkl_fsel_q),
    .i_alt_out(i_alt_ijkl_out),
    .i_alt_oe(i_alt_ijkl_oe),
    .i_pin(i_port_ijkl_in),
    .o_out(o_port_ijkl_out),
    .o_oe(o_port_ijkl_oe),
    .o_in(ijkl_in)
  );

  spmc_port #(.W(8)) u_m (
    .i_clk(i_clk),
    .i_rstn(rstn_int),
    .i_data(m_data_q),
    .i_dir(m_dir_q),
    .i_fsel(8'h0),
    .i_alt_out(8'h0),
    .i_alt_oe(8'h0),
    .i_pin(i_port_m_in),
    .o_out(o_port_m_out),
    .o_oe(o_port_m_oe),
    .o_in(m_in)
  );

  // Lines used as interrupt inputs are never driven
  spmc_port #(.W(8)) u_q (
    .i_clk(i_clk),
    .i_rstn(rstn_int),
    .i_data(q_data_q),
    .i_dir(q_dir_q & ~q_isel_q),
    .i_fsel(8'h0),
    .i_alt_out(8'h0),
    .i_alt_oe(8'h0),
    .i_pin(i_port_q_in),
    .o_out(o_port_q_out),
    .o_oe(o_port_q_oe),
    .o_in(q_in)
  );

  assign o_irq = irq_q;
  assign o_irq_request = irq_req_q;
  assign o_reset_indication = rst_ind_q;
  assign o_timer_stop = tstop_q;
  assign o_config = cfg_q;
endmodule

// ===== verilog/spmc_pkg.sv
// Constants, register map and types for the port and configuration block.
// Assumes an APB master on one 100 MHz clock; pprot[0] marks supervisor.
// Notes on behaviour
// - Reset input asserted holds the block and bus devices in reset.
// - Reset indication output is high while in reset, low otherwise.
// - Pins not used by the bus interface can be general inputs/outputs.
// - Ports A and B: eight output lines each, shared data and select.
// - Ports I to L bidirectional, shared data, direction, select registers.
// - Port A, B, I, J, K, L register accesses take three clocks.
// - Port M: eight bidirectional lines, accesses take two clocks.
// - Port Q: eight bidirectional lines, accesses take two clocks.
// - Eight interrupt request inputs, each requesting its own index level.
// - Request pins not used as interrupts serve as port Q lines.
// - Configuration register reachable only in supervisor mode.
// - Configuration fields at fixed places; part and mask codes read-only.
// - Freeze enable stops the timers while the freeze signal is high.
// - Lock bit refuses configuration writes; cleared only in freeze.
// - Privilege field: 00 open, 01/11 supervisor, 10 supervisor writes.
// - Show-cycle field: 00 none, 01 writes, 11 all, 10 reserved.
package spmc_pkg;
  localparam logic [31:0] A_CFG = 32'h8007FC00;
  localparam logic [31:0] A_AB_DATA = 32'h8007FC10;
  localparam logic [31:0] A_AB_FSEL = 32'h8007FC14;
  localparam logic [31:0] A_IJKL_DATA = 32'h8007FC18;
  localparam logic [31:0] A_IJKL_DIR = 32'h8007FC1C;
  localparam logic [31:0] A_IJKL_FSEL = 32'h8007FC20;
  localparam logic [31:0] A_M_DATA = 32'h8007FC24;
  localparam logic [31:0] A_M_DIR = 32'h8007FC28;
  localparam logic [31:0] A_Q_DATA = 32'h8007FC2C;
  localparam logic [31:0] A_Q_DIR = 32'h8007FC30;
  localparam logic [31:0] A_Q_IRQSEL = 32'h8007FC34;
  localparam logic [31:0] A_INT_STATUS = 32'h8007FC38;
  localparam logic [31:0] A_INT_CLEAR = 32'h8007FC3C;
  localparam logic [31:0] A_INT_ENABLE = 32'h8007FC40;
  // Configuration field positions, big-endian bit 0 is register bit 31
  localparam int B_FRZ = 31;
  localparam int B_CHKSTOP = 28;
  localparam int B_BURST = 27;
  localparam int B_PRIV_HI = 25;
  localparam int B_PRIV_LO = 24;
  localparam int B_DBG_LOCK = 23;
  localparam int B_REG_LOCK = 22;
  localparam int B_SHOW_HI = 17;
  localparam int B_SHOW_LO = 16;
  localparam int B_PART_HI = 15;
  localparam int B_PART_LO = 8;
  localparam int B_MASK_HI = 7;
  localparam int B_MASK_LO = 0;
  // Access latencies in clock cycles
  localparam logic [1:0] LAT_SLOW = 2'h3;
  localparam logic [1:0] LAT_FAST = 2'h2;
  // Privilege and show-cycle codes
  localparam logic [1:0] PRIV_OPEN = 2'h0;
  localparam logic [1:0] PRIV_WR_ONLY = 2'h2;
  localparam logic [1:0] SHOW_RESERVED = 2'h2;
  localparam int N_IRQ = 8;
  localparam int STS_W = 9;
  localparam int STS_LOCK = 8;

  typedef struct packed {
    logic timer_freeze_enable;
    logic checkstop_reset_enable;
    logic burst_style_select;
    logic [1:0] privilege_field;
    logic debug_lock_bit;
    logic register_lock_bit;
    logic [1:0] internal_bus_show_cycles;
  } spmc_cfg_t;

  localparam spmc_cfg_t CFG_RESET = '0;

  // Access allowed under the privilege field
  function automatic logic priv_ok(input logic [1:0] priv,
                                   input logic privileged, input logic wr);
    priv_ok = privileged || (priv == PRIV_OPEN)
      || (priv == PRIV_WR_ONLY && !wr);
  endfunction

  // Pin read-back: driven bits from the latch, others from the pin
  function automatic logic [31:0] mix(input logic [31:0] lat,
                                      input logic [31:0] pin,
                                      input logic [31:0] dir);
    mix = (lat & dir) | (pin & ~dir);
  endfunction
endpackage

// ===== verilog/spmc_wait.sv
// APB answer timing: holds pready low until the access has run its length.
// Assumes the master holds the request stable until pready is seen.
module spmc_wait (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic [1:0] i_need,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata
);
  import spmc_pkg::*;

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ready_q;
  logic ready_d;
  logic hit;

  assign hit = i_psel && !ready_q && (cnt_q == i_need - 2'h2);
  assign ready_d = hit;
  assign cnt_d = (!i_psel || ready_q) ? 2'h0 : cnt_q + 2'h1;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      o_pslverr <= hit && i_err;
      o_prdata <= (hit && !i_err) ? i_rdata : 32'h0;
    end
  end

  assign o_pready = ready_q;
endmodule

// ===== verilog/spmc_port.sv
// One group of port lines: pin drive, output enable and input sampling.
// Assumes pin inputs are synchronous to the clock.
module spmc_port #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_data,
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_fsel,
  input wire logic [W-1:0] i_alt_out,
  input wire logic [W-1:0] i_alt_oe,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_out,
  output logic [W-1:0] o_oe,
  output logic [W-1:0] o_in
);
  logic [W-1:0] out_d;
  logic [W-1:0] oe_d;

  // Select port or alternate function per line
  assign out_d = (i_fsel & i_alt_out) | (~i_fsel & i_data);
  assign oe_d = (i_fsel & i_alt_oe) | (~i_fsel & i_dir);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_out <= '0;
      o_oe <= '0;
      o_in <= '0;
    end else begin
      o_out <= out_d;
      o_oe <= oe_d;
      o_in <= i_pin;
    end
  end
endmodule

// ===== bench/spmc_monitor.sv
// Protocol and register checks on the port and configuration block.
// Assumes it is bound to spmc_top and sees only that module's ports.
module spmc_monitor
  import spmc_pkg::*;
#(
  parameter logic [7:0] PART_CODE = 8'h5A,
  parameter logic [7:0] MASK_REV = 8'h01
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ext_reset_n,
  input wire logic i_freeze,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [2:0] i_pprot,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic o_irq,
  input wire logic o_reset_indication,
  input wire logic o_timer_stop,
  input wire spmc_pkg::spmc_cfg_t o_config
);
  wire logic setup = i_psel && !i_penable;
  wire logic done = i_psel && i_penable && o_pready;
  wire logic cfg = i_paddr == A_CFG;
  wire logic slow = i_paddr inside {A_AB_DATA, A_AB_FSEL, A_IJKL_DATA,
                                    A_IJKL_DIR, A_IJKL_FSEL};
  wire logic fast = i_paddr inside {A_CFG, A_M_DATA, A_M_DIR, A_Q_DATA,
                                    A_Q_DIR};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !i_ext_reset_n);

  a_reset_ind_high: assert property (disable iff (1'h0)
    (!i_rstn || !i_ext_reset_n) |=> o_reset_indication)
    else $error("reset ind low");
  a_reset_ind_low: assert property (disable iff (1'h0)
    (i_rstn && i_ext_reset_n) |=> !o_reset_indication)
    else $error("reset ind high");
  a_reset_quiet: assert property (disable iff (1'h0)
    (!i_rstn || !i_ext_reset_n) |=> !o_pready && !o_irq
    && o_config == '0) else $error("not reset");
  a_slow_latency: assert property (
    setup && slow |=> !o_pready ##1 o_pready)
    else $error("slow access latency");
  a_fast_latency: assert property (setup && fast |=> o_pready)
    else $error("fast access latency");
  a_cfg_user_refused: assert property (
    done && cfg && !i_pprot[0] |-> o_pslverr)
    else $error("user config access taken");
  a_cfg_read_fixed: assert property (
    done && cfg && !i_pwrite && !o_pslverr |->
    o_prdata[15:0] == {PART_CODE, MASK_REV} && o_prdata[30:29] == 2'h0 &&
    !o_prdata[26] && o_prdata[21:18] == 4'h0)
    else $error("config fixed bits");
  a_lock_refuses: assert property (
    done && cfg && i_pwrite && i_pprot[0] &&
    o_config.register_lock_bit && !i_freeze
    |-> o_pslverr ##1 $stable(o_config))
    else $error("locked write taken");
  a_freeze_stops: assert property (
    i_freeze && o_config.timer_freeze_enable |=> o_timer_stop)
    else $error("timers not stopped");
  a_timers_run: assert property (!i_freeze |=> !o_timer_stop)
    else $error("timers stopped");
endmodule

bind spmc_top spmc_monitor #(.PART_CODE(PART_CODE), .MASK_REV(MASK_REV))
  spmc_monitor_i (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_ext_reset_n(i_ext_reset_n), .i_freeze(i_freeze), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pprot(i_pprot), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_prdata(o_prdata), .o_irq(o_irq), .o_reset_indication(o_reset_indication),
  .o_timer_stop(o_timer_stop), .o_config(o_config));

// ===== bench/spmc_pins.sv
// Outside devices on the bidirectional port and interrupt pins.
// Assumes the bench sets what those devices drive on undriven lines.
module spmc_pins (
  input wire logic [31:0] i_ijkl_out,
  input wire logic [31:0] i_ijkl_oe,
  input wire logic [31:0] i_ijkl_ext,
  input wire logic [7:0] i_m_out,
  input wire logic [7:0] i_m_oe,
  input wire logic [7:0] i_m_ext,
  input wire logic [7:0] i_q_out,
  input wire logic [7:0] i_q_oe,
  input wire logic [7:0] i_q_ext,
  output logic [31:0] o_ijkl_pin,
  output logic [7:0] o_m_pin,
  output logic [7:0] o_q_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level: block where enabled, outside device elsewhere
  assign o_ijkl_pin = (i_ijkl_out & i_ijkl_oe)
    | (i_ijkl_ext & ~i_ijkl_oe);
  assign o_m_pin = (i_m_out & i_m_oe) | (i_m_ext & ~i_m_oe);
  assign o_q_pin = (i_q_out & i_q_oe) | (i_q_ext & ~i_q_oe);
endmodule

// ===== bench/spmc_top_bench.sv
// Self-checking bench for the port and configuration block.
// Assumes spmc_top, spmc_pins and the bound monitor are compiled before.
module spmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spmc_pkg::*;
  localparam logic [7:0] PC = 8'hC3; // Arbitrary value
  localparam logic [7:0] MR = 8'h2B; // Arbitrary value
  localparam logic [31:0] FIX = {16'h0000, PC, MR};
  logic i_clk = 1'h0;
  logic i_rstn, i_ext_reset_n, i_freeze, i_psel, i_penable, i_pwrite, er;
  logic o_pready, o_pslverr, o_irq, o_reset_indication, o_timer_stop;
  logic [2:0] i_pprot;
  logic [31:0] i_paddr, i_pwdata, o_prdata, rd, ijkl_ext, pin_ijkl;
  logic [31:0] i_alt_ijkl_out, i_alt_ijkl_oe, o_port_ijkl_out, o_port_ijkl_oe;
  logic [15:0] i_alt_ab_out, o_port_ab_lines;
  logic [7:0] m_ext, q_ext, pin_m, pin_q, o_port_m_out, o_port_m_oe;
  logic [7:0] o_port_q_out, o_port_q_oe, o_irq_request;
  spmc_cfg_t o_config;
  int error_cnt = 0;
  int comparisons = 0;

  always #5 i_clk = ~i_clk;

  spmc_top #(.PART_CODE(PC), .MASK_REV(MR)) spmc_top_i (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_ext_reset_n(i_ext_reset_n), .i_freeze(i_freeze),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pprot(i_pprot),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .i_alt_ab_out(i_alt_ab_out), .o_port_ab_lines(o_port_ab_lines),
    .i_alt_ijkl_out(i_alt_ijkl_out), .i_alt_ijkl_oe(i_alt_ijkl_oe),
    .i_port_ijkl_in(pin_ijkl), .o_port_ijkl_out(o_port_ijkl_out),
    .o_port_ijkl_oe(o_port_ijkl_oe), .i_port_m_in(pin_m),
    .o_port_m_out(o_port_m_out), .o_port_m_oe(o_port_m_oe),
    .i_port_q_in(pin_q), .o_port_q_out(o_port_q_out),
    .o_port_q_oe(o_port_q_oe), .o_irq_request(o_irq_request), .o_irq(o_irq),
    .o_reset_indication(o_reset_indication), .o_timer_stop(o_timer_stop),
    .o_config(o_config));

  spmc_pins spmc_pins_i (.i_ijkl_out(o_port_ijkl_out),
    .i_ijkl_oe(o_port_ijkl_oe), .i_ijkl_ext(ijkl_ext), .i_m_out(o_port_m_out),
    .i_m_oe(o_port_m_oe), .i_m_ext(m_ext), .i_q_out(o_port_q_out),
    .i_q_oe(o_port_q_oe), .i_q_ext(q_ext), .o_ijkl_pin(pin_ijkl),
    .o_m_pin(pin_m), .o_q_pin(pin_q));

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer, called just after a rising edge; checks the error flag
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic s, input logic e);
    logic ok;
    ok = 1'h0;
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_paddr <= a;
    i_pwrite <= w;
    i_pwdata <= d;
    i_pprot <= {2'h0, s};
    @(posedge i_clk);
    i_penable <= 1'h1;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge i_clk);
      ok = (o_pready === 1'h1);
      rd = o_prdata;
      er = o_pslverr;
    end
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] %0t no bus answer", $time);
      stop_test();
    end else begin
      chk({31'h0, er}, {31'h0, e});
      @(posedge i_clk);
    end
  endtask

  initial begin
    i_rstn = 1'h0;
    i_ext_reset_n = 1'h1;
    i_freeze = 1'h0;
    i_psel = 1'h0;
    i_penable = 1'h0;
    i_pwrite = 1'h0;
    i_paddr = 32'h0;
    i_pwdata = 32'h0;
    i_pprot = 3'h0;
    i_alt_ab_out = 16'h3C3C;
    i_alt_ijkl_out = 32'h000000A5;
    i_alt_ijkl_oe = 32'h000000FF;
    ijkl_ext = 32'hCAFEBABE;
    m_ext = 8'h3C;
    q_ext = 8'h00;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_reset_indication}, 32'h1);
    @(posedge i_clk);
    i_rstn <= 1'h1;
    @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_reset_indication}, 32'h0);
    chk({23'h0, o_config}, 32'h0);
    @(posedge i_clk);
    apb(A_CFG, 1'h0, 32'h0, 1'h0, 1'h1);
    apb(A_CFG, 1'h1, 32'hFFFFFFFF, 1'h0, 1'h1);
    apb(A_CFG, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, FIX);
    apb(A_CFG, 1'h1, 32'h80020000, 1'h1, 1'h0);
    apb(A_CFG, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h80000000 | FIX);
    apb(A_CFG, 1'h1, 32'h8001FFFF, 1'h1, 1'h0);
    apb(A_CFG, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h80010000 | FIX);
    i_freeze <= 1'h1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_timer_stop}, 32'h1);
    @(posedge i_clk);
    i_freeze <= 1'h0;
    apb(A_CFG, 1'h1, 32'hFFFFFFFF, 1'h1, 1'h0);
    apb(A_CFG, 1'h1, 32'h0, 1'h1, 1'h1);
    apb(A_CFG, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h9B430000 | FIX);
    i_freeze <= 1'h1;
    apb(A_CFG, 1'h1, 32'h0, 1'h1, 1'h0);
    apb(A_CFG, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, FIX);
    i_freeze <= 1'h0;
    for (int p = 0; p < 4; p++) begin
      apb(A_CFG, 1'h1, {6'h00, p[1:0], 24'h000000}, 1'h1, 1'h0);
      apb(A_M_DATA, 1'h1, 32'h0, 1'h0, p != 0);
      apb(A_M_DATA, 1'h0, 32'h0, 1'h0, p[0]);
    end
    apb(32'h8007FC80, 1'h0, 32'h0, 1'h1, 1'h1);
    apb(A_AB_DATA, 1'h1, 32'h0000A55A, 1'h1, 1'h0);
    apb(A_AB_FSEL, 1'h1, 32'h0000FF00, 1'h1, 1'h0);
    apb(A_AB_DATA, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h0000A55A);
    apb(A_IJKL_DIR, 1'h1, 32'hFFFF0000, 1'h1, 1'h0);
    apb(A_IJKL_FSEL, 1'h1, 32'h000000FF, 1'h1, 1'h0);
    apb(A_IJKL_DATA, 1'h1, 32'h12345678, 1'h1, 1'h0);
    apb(A_IJKL_DATA, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h1234BAA5);
    apb(A_M_DIR, 1'h1, 32'h0F, 1'h1, 1'h0);
    apb(A_M_DATA, 1'h1, 32'hA5, 1'h1, 1'h0);
    apb(A_M_DATA, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h35);
    @(negedge i_clk);
    chk({16'h0, o_port_ab_lines}, 32'h00003C5A);
    chk(o_port_ijkl_oe, 32'hFFFF00FF);
    chk(o_port_ijkl_out, 32'h123456A5);
    chk({24'h0, o_port_m_out}, 32'hA5);
    chk({24'h0, o_port_m_oe}, 32'h0F);
    @(posedge i_clk);
    apb(A_Q_IRQSEL, 1'h1, 32'h81, 1'h1, 1'h0);
    apb(A_Q_DIR, 1'h1, 32'h8E, 1'h1, 1'h0);
    apb(A_Q_DATA, 1'h1, 32'hFF, 1'h1, 1'h0);
    apb(A_INT_ENABLE, 1'h1, 32'h002, 1'h1, 1'h0);
    q_ext <= 8'hFF;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk({24'h0, o_irq_request}, 32'h81);
    chk({24'h0, o_port_q_oe}, 32'h0E);
    chk({24'h0, o_port_q_out}, 32'hFF);
    chk({31'h0, o_irq}, 32'h0);
    @(posedge i_clk);
    apb(A_INT_ENABLE, 1'h1, 32'h001, 1'h1, 1'h0);
    @(negedge i_clk);
    chk({31'h0, o_irq}, 32'h1);
    @(posedge i_clk);
    q_ext <= 8'h00;
    apb(A_INT_STATUS, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h181);
    apb(A_INT_CLEAR, 1'h1, 32'h1FF, 1'h1, 1'h0);
    apb(A_INT_STATUS, 1'h0, 32'h0, 1'h1, 1'h0);
    chk(rd, 32'h0);
    i_ext_reset_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_reset_indication}, 32'h1);
    chk({23'h0, o_config}, 32'h0);
    chk({16'h0, o_port_ab_lines}, 32'h0);
    @(posedge i_clk);
    i_ext_reset_n <= 1'h1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk({31'h0, o_reset_indication}, 32'h0);
    stop_test();
  end
endmodule
